// >>> src/dvb_valve_io.sv
// Discrete valve I/O, gauge range readback and two-channel solenoid sequencer.
// Assumes TTL pins are asynchronous; position, pressure and set point words
// come from converters on MCLK.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
module dvb_valve_io
    import dvb_pkg::*;
#(
    parameter int MS_TICKS = MS_CYCLES,
    parameter bit SEALING = 1'b1,
    parameter bit HAS_PRESET = 1'b1
) (
    input wire logic MCLK,
    input wire logic ARST_N,
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic ANALOG_SETPOINT_SEL_N,
    input wire logic SECOND_GAUGE_SEL_N,
    input wire logic CLOSE_CMD_N,
    input wire logic OPEN_CMD_N,
    input wire logic POSITION_SEL_N,
    input wire logic PRESET_POS_N,
    input wire logic INIT_EN_N,
    input wire logic [15:0] ANALOG_SP,
    input wire logic [15:0] PRESS_PRIMARY,
    input wire logic [15:0] PRESS_SECONDARY,
    input wire logic [15:0] VALVE_POS,
    input wire logic [15:0] ROTARY_POS,
    output logic DRIVE_OPEN,
    output logic DRIVE_CLOSE,
    output logic FAULT,
    output logic AT_PRESET_N,
    output logic VALVE_CLOSED_N,
    output logic VALVE_OPEN_N,
    output logic [1:0] SOLENOID_ON
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NPIN-1:0] s1, s2, s3, pin;
        logic aw_got, w_got, bvalid, rvalid;
        logic [7:0] aw_addr;
        logic [31:0] w_data, rdata;
        logic [3:0] w_strb;
        logic [1:0] bresp, rresp;
        logic [2:0] cmd;
        logic serial_ovr;
        logic [7:0] tog_cnt;
        logic [15:0] ms_cnt, sp_reg;
        logic [19:0] range1, range2, quo;
        logic [20:0] rem;
        logic div_busy, ratio_lim;
        logic [4:0] div_cnt;
        logic [9:0] ratio;
        logic [1:0] burp_en, bon;
        logic [1:0][15:0] delta;
        logic [1:0][14:0] btime, bcnt;
        dvb_init_type init;
        logic press_prev, drv_open, drv_close, fault, at_pre_n, closed_n, open_n;
    } dvb_state_type;

    dvb_state_type q_ff, nxt_q;

    function automatic logic [1:0] seek(input logic [15:0] pos, input logic [15:0] tgt);
        seek = {({1'b0, pos} + {1'b0, POS_TOL} < {1'b0, tgt}),
                ({1'b0, pos} > {1'b0, tgt} + {1'b0, POS_TOL})};
    endfunction : seek

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
        for (int b = 0; b < 4; b++) begin
            merge[b*8 +: 8] = st[b] ? d[b*8 +: 8] : old[b*8 +: 8];
        end
    endfunction : merge

    logic ms_tick, analog_mode, pos_mode, press_act, burp_start, is_closed, is_open;
    logic aw_hs, w_hs, ar_hs, cfg_err;
    logic [15:0] sp_eff, press_meas;
    logic [16:0] perr;
    logic [1:0] mv;
    logic [20:0] trial;
    logic [31:0] wv;

    assign S_AXI_AWREADY = !q_ff.aw_got && !q_ff.bvalid;
    assign S_AXI_WREADY = !q_ff.w_got && !q_ff.bvalid;
    assign S_AXI_ARREADY = !q_ff.rvalid;
    assign S_AXI_BVALID = q_ff.bvalid;
    assign S_AXI_BRESP = q_ff.bresp;
    assign S_AXI_RVALID = q_ff.rvalid;
    assign S_AXI_RDATA = q_ff.rdata;
    assign S_AXI_RRESP = q_ff.rresp;
    assign DRIVE_OPEN = q_ff.drv_open;
    assign DRIVE_CLOSE = q_ff.drv_close;
    assign FAULT = q_ff.fault;
    assign AT_PRESET_N = q_ff.at_pre_n;
    assign VALVE_CLOSED_N = q_ff.closed_n;
    assign VALVE_OPEN_N = q_ff.open_n;
    assign SOLENOID_ON = q_ff.bon;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.s1 = {INIT_EN_N, PRESET_POS_N, POSITION_SEL_N, OPEN_CMD_N, CLOSE_CMD_N,
                    SECOND_GAUGE_SEL_N, ANALOG_SETPOINT_SEL_N};
        nxt_q.s2 = q_ff.s1;
        nxt_q.s3 = q_ff.s2;
        for (int k = 0; k < NPIN; k++) begin
            if (q_ff.s2[k] == q_ff.s3[k]) begin
                nxt_q.pin[k] = q_ff.s3[k];
            end
        end
        ms_tick = (q_ff.ms_cnt == 16'(MS_TICKS - 1));
        nxt_q.ms_cnt = ms_tick ? 16'h0000 : q_ff.ms_cnt + 16'h0001;

        analog_mode = !q_ff.serial_ovr && !q_ff.pin[P_ASEL];
        pos_mode = analog_mode && !q_ff.pin[P_POSSEL];
        press_act = (q_ff.init == INIT_READY) && (q_ff.serial_ovr ?
                    (q_ff.cmd == CMD_PRESS) : (analog_mode && q_ff.pin[P_POSSEL]));
        sp_eff = analog_mode ? ANALOG_SP : q_ff.sp_reg;
        press_meas = q_ff.pin[P_GSEL] ? PRESS_PRIMARY : PRESS_SECONDARY;
        perr = {1'b0, sp_eff} - {1'b0, press_meas};
        is_closed = (VALVE_POS == 16'h0000);
        is_open = (VALVE_POS >= POS_FULL);

        // Leaving serial control needs the select held high for 200 ms.
        if (q_ff.serial_ovr) begin
            if (q_ff.pin[P_ASEL]) begin
                if (ms_tick && q_ff.tog_cnt < 8'(TOGGLE_MS)) begin
                    nxt_q.tog_cnt = q_ff.tog_cnt + 8'h01;
                end
            end else begin
                if (q_ff.tog_cnt >= 8'(TOGGLE_MS)) begin
                    nxt_q.serial_ovr = 1'b0;
                end
                nxt_q.tog_cnt = 8'h00;
            end
        end

        // ------------------------------------------------------------
        // Valve drive
        // ------------------------------------------------------------
        mv = 2'b00;
        case (q_ff.init)
            INIT_SAFE: begin
                if (!SEALING) begin
                    nxt_q.init = INIT_READY;
                end else if (!q_ff.pin[P_INIT]) begin
                    nxt_q.init = INIT_RUN;
                end
            end
            INIT_RUN: begin
                mv = {1'b0, !is_closed};
                if (is_closed) begin
                    nxt_q.init = INIT_READY;
                end
            end
            INIT_READY: begin
                if (!q_ff.pin[P_CLOSE]) begin
                    mv = {1'b0, !is_closed};
                end else if (!q_ff.pin[P_OPEN]) begin
                    mv = {!is_open, 1'b0};
                end else if (HAS_PRESET && !q_ff.pin[P_PRESET]) begin
                    mv = seek(VALVE_POS, ROTARY_POS);
                end else if (q_ff.serial_ovr) begin
                    case (q_ff.cmd)
                        CMD_OPEN: mv = {!is_open, 1'b0};
                        CMD_CLOSE: mv = {1'b0, !is_closed};
                        CMD_POS: mv = seek(VALVE_POS, q_ff.sp_reg);
                        default: mv = 2'b00;
                    endcase
                end else if (pos_mode) begin
                    mv = seek(VALVE_POS, ANALOG_SP);
                end
            end
            default: nxt_q.init = INIT_SAFE;
        endcase
        nxt_q.drv_open = mv[1];
        nxt_q.drv_close = mv[0];
        nxt_q.at_pre_n = !(HAS_PRESET && seek(VALVE_POS, ROTARY_POS) == 2'b00);
        nxt_q.closed_n = !is_closed;
        nxt_q.open_n = !is_open;
        cfg_err = (q_ff.range2 != 20'h00000) && (q_ff.range1 <= q_ff.range2);
        nxt_q.fault = cfg_err || q_ff.ratio_lim;

        // ------------------------------------------------------------
        // Solenoid channels
        // ------------------------------------------------------------
        nxt_q.press_prev = press_act;
        burp_start = press_act && !q_ff.press_prev;
        for (int i = 0; i < 2; i++) begin
            if (burp_start && q_ff.burp_en[i] && !perr[16]
                && perr[15:0] > q_ff.delta[i]) begin
                nxt_q.bon[i] = 1'b1;
                nxt_q.bcnt[i] = 15'h0000;
            end else if (q_ff.bon[i] && ms_tick) begin
                if (q_ff.bcnt[i] + 15'h0001 >= q_ff.btime[i]) begin
                    nxt_q.bon[i] = 1'b0;
                end else begin
                    nxt_q.bcnt[i] = q_ff.bcnt[i] + 15'h0001;
                end
            end
        end

        // ------------------------------------------------------------
        // Range ratio divider, one quotient bit per cycle
        // ------------------------------------------------------------
        trial = {q_ff.rem[19:0], q_ff.quo[19]} - {1'b0, q_ff.range2};
        if (q_ff.div_busy) begin
            if (!trial[20]) begin
                nxt_q.rem = trial;
                nxt_q.quo = {q_ff.quo[18:0], 1'b1};
            end else begin
                nxt_q.rem = {q_ff.rem[19:0], q_ff.quo[19]};
                nxt_q.quo = {q_ff.quo[18:0], 1'b0};
            end
            nxt_q.div_cnt = q_ff.div_cnt - 5'h01;
            if (q_ff.div_cnt == 5'h01) begin
                nxt_q.div_busy = 1'b0;
                // An unconnected second gauge (range 0) gives no ratio and no fault.
                nxt_q.ratio_lim = (q_ff.range2 != 20'h00000) && (nxt_q.quo > 20'(RATIO_MAX));
                if (q_ff.range2 == 20'h00000) begin
                    nxt_q.ratio = 10'h000;
                end else if (nxt_q.quo > 20'(RATIO_MAX)) begin
                    nxt_q.ratio = 10'(RATIO_MAX);
                end else begin
                    nxt_q.ratio = nxt_q.quo[9:0];
                end
            end
        end

        // ------------------------------------------------------------
        // Register bus, served whatever the pin levels
        // ------------------------------------------------------------
        aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
        w_hs = S_AXI_WVALID && S_AXI_WREADY;
        ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
        if (aw_hs) begin
            nxt_q.aw_got = 1'b1;
            nxt_q.aw_addr = S_AXI_AWADDR;
        end
        if (w_hs) begin
            nxt_q.w_got = 1'b1;
            nxt_q.w_data = S_AXI_WDATA;
            nxt_q.w_strb = S_AXI_WSTRB;
        end
        if (q_ff.bvalid && S_AXI_BREADY) begin
            nxt_q.bvalid = 1'b0;
        end
        wv = 32'h0000_0000;
        if (q_ff.aw_got && q_ff.w_got) begin
            nxt_q.aw_got = 1'b0;
            nxt_q.w_got = 1'b0;
            nxt_q.bvalid = 1'b1;
            nxt_q.bresp = 2'b00;
            case (q_ff.aw_addr)
                ADDR_CMD: begin
                    wv = merge({29'h0, q_ff.cmd}, q_ff.w_data, q_ff.w_strb);
                    nxt_q.cmd = wv[2:0];
                    nxt_q.serial_ovr = 1'b1;
                    nxt_q.tog_cnt = 8'h00;
                end
                ADDR_SETPT: begin
                    wv = merge({16'h0, q_ff.sp_reg}, q_ff.w_data, q_ff.w_strb);
                    nxt_q.sp_reg = wv[15:0];
                end
                ADDR_RANGE1, ADDR_RANGE2: begin
                    wv = merge({12'h0, (q_ff.aw_addr == ADDR_RANGE1) ? q_ff.range1
                               : q_ff.range2}, q_ff.w_data, q_ff.w_strb);
                    if (q_ff.aw_addr == ADDR_RANGE1) begin
                        nxt_q.range1 = wv[19:0];
                        nxt_q.quo = wv[19:0];
                    end else begin
                        nxt_q.range2 = wv[19:0];
                        nxt_q.quo = q_ff.range1;
                    end
                    nxt_q.rem = 21'h000000;
                    nxt_q.div_cnt = 5'h14;
                    nxt_q.div_busy = 1'b1;
                end
                ADDR_BURP_EN: begin
                    wv = merge({30'h0, q_ff.burp_en}, q_ff.w_data, q_ff.w_strb);
                    nxt_q.burp_en = wv[1:0];
                end
                ADDR_DELTA0, ADDR_DELTA1: begin
                    wv = merge({16'h0, q_ff.delta[q_ff.aw_addr[2]]}, q_ff.w_data,
                               q_ff.w_strb);
                    nxt_q.delta[q_ff.aw_addr[2]] = wv[15:0];
                end
                ADDR_TIME0, ADDR_TIME1: begin
                    wv = merge({17'h0, q_ff.btime[q_ff.aw_addr[2]]}, q_ff.w_data,
                               q_ff.w_strb);
                    nxt_q.btime[q_ff.aw_addr[2]] = (wv > 32'(BURP_MAX_MS)) ?
                        15'(BURP_MAX_MS) : wv[14:0];
                end
                ADDR_STATUS, ADDR_RATIO: nxt_q.bresp = 2'b00;
                default: nxt_q.bresp = 2'b10;
            endcase
        end
        if (q_ff.rvalid && S_AXI_RREADY) begin
            nxt_q.rvalid = 1'b0;
        end
        if (ar_hs) begin
            nxt_q.rvalid = 1'b1;
            nxt_q.rresp = 2'b00;
            case (S_AXI_ARADDR)
                ADDR_CMD: nxt_q.rdata = {29'h0, q_ff.cmd};
                ADDR_STATUS: nxt_q.rdata = {12'h0, q_ff.fault, q_ff.ratio_lim,
                    q_ff.init, q_ff.bon, q_ff.drv_open, q_ff.drv_close, pos_mode,
                    press_act, analog_mode, q_ff.serial_ovr, 1'b0, q_ff.pin};
                ADDR_SETPT: nxt_q.rdata = {16'h0, q_ff.sp_reg};
                ADDR_RANGE1: nxt_q.rdata = {4'h1, 8'h00, q_ff.range1};
                ADDR_RANGE2: nxt_q.rdata = {4'h2, 8'h00, q_ff.range2};
                ADDR_RATIO: nxt_q.rdata = {q_ff.div_busy, 21'h0, q_ff.ratio};
                ADDR_BURP_EN: nxt_q.rdata = {30'h0, q_ff.burp_en};
                ADDR_DELTA0, ADDR_DELTA1: nxt_q.rdata = {16'h0, q_ff.delta[S_AXI_ARADDR[2]]};
                ADDR_TIME0, ADDR_TIME1: nxt_q.rdata = {17'h0, q_ff.btime[S_AXI_ARADDR[2]]};
                default: begin
                    nxt_q.rdata = 32'h0000_0000;
                    nxt_q.rresp = 2'b10;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            q_ff <= '0;
            q_ff.s1 <= '1;
            q_ff.s2 <= '1;
            q_ff.s3 <= '1;
            q_ff.pin <= '1;
            q_ff.range1 <= RANGE1_RST;
            q_ff.range2 <= RANGE2_RST;
            q_ff.delta <= {DELTA_RST, DELTA_RST};
            q_ff.btime <= {TIME_RST, TIME_RST};
            q_ff.init <= INIT_SAFE;
            q_ff.at_pre_n <= 1'b1;
            q_ff.closed_n <= 1'b1;
            q_ff.open_n <= 1'b1;
        end else begin
            q_ff <= nxt_q;
        end
    end
    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    close_drive_a: assert property (q_ff.init == INIT_READY && !q_ff.pin[P_CLOSE]
        && VALVE_POS != 16'h0000 |=> DRIVE_CLOSE && !DRIVE_OPEN) else $error("close");
    open_drive_a: assert property (q_ff.init == INIT_READY && q_ff.pin[P_CLOSE]
        && !q_ff.pin[P_OPEN] && !is_open |=> DRIVE_OPEN) else $error("open");
    write_answer_a: assert property (aw_hs && w_hs |=> ##1 S_AXI_BVALID)
        else $error("no write answer");
    toggle_exit_a: assert property ($fell(q_ff.serial_ovr) |->
        $past(q_ff.tog_cnt) >= 8'(TOGGLE_MS)) else $error("early analog");
    fault_out_a: assert property (cfg_err |=> FAULT) else $error("fault");
    preset_window_a: assert property (!AT_PRESET_N |->
        $past(seek(VALVE_POS, ROTARY_POS)) == 2'b00) else $error("preset");
    closed_flag_a: assert property (!VALVE_CLOSED_N |-> $past(VALVE_POS) == 16'h0000)
        else $error("closed flag");
    burp_fire_a: assert property (burp_start && q_ff.burp_en[0] && !perr[16]
        && perr[15:0] > q_ff.delta[0] |=> SOLENOID_ON[0]) else $error("burp fire");
    burp_end_a: assert property ($fell(q_ff.bon[1]) |->
        $past(q_ff.bcnt[1]) + 15'h0001 >= $past(q_ff.btime[1])) else $error("burp end");
    ratio_cap_a: assert property (q_ff.ratio <= 10'(RATIO_MAX)) else $error("ratio");
    time_cap_a: assert property (q_ff.btime[0] <= 15'(BURP_MAX_MS)) else $error("time");
    both_burp_c: cover property (SOLENOID_ON == 2'b11);
    init_done_c: cover property (q_ff.init == INIT_RUN ##1 q_ff.init == INIT_READY);
    serial_exit_c: cover property ($fell(q_ff.serial_ovr));
endmodule : dvb_valve_io

// >>> src/dvb_pkg.sv
// Constants shared by the valve I/O and solenoid sequencer block.
// Assumes one 40 MHz clock and an AXI4-Lite register bus.
package dvb_pkg;
    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
    localparam int TOGGLE_MS = 200;
    localparam int BURP_MAX_MS = 30_000;
    // ----------------------------------------------------------------
    // Scales: position and pressure are hundredths of a percent
    // ----------------------------------------------------------------
    localparam int RATIO_MAX = 1000;
    localparam logic [15:0] POS_FULL = 16'h2710;
    localparam int TOL_PERMILLE = 5;
    localparam logic [15:0] POS_TOL = 16'(10000 * TOL_PERMILLE / 1000);
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SETPT = 8'h08;
    localparam logic [7:0] ADDR_RANGE1 = 8'h10;
    localparam logic [7:0] ADDR_RANGE2 = 8'h14;
    localparam logic [7:0] ADDR_RATIO = 8'h18;
    localparam logic [7:0] ADDR_BURP_EN = 8'h1C;
    localparam logic [7:0] ADDR_DELTA0 = 8'h20;
    localparam logic [7:0] ADDR_DELTA1 = 8'h24;
    localparam logic [7:0] ADDR_TIME0 = 8'h28;
    localparam logic [7:0] ADDR_TIME1 = 8'h2C;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [19:0] RANGE1_RST = 20'h003E8;
    localparam logic [19:0] RANGE2_RST = 20'h00000;
    localparam logic [15:0] DELTA_RST = 16'h03E8;
    localparam logic [14:0] TIME_RST = 15'h03E8;
    // ----------------------------------------------------------------
    // Serial valve commands and pin indices
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_OPEN = 3'h1;
    localparam logic [2:0] CMD_CLOSE = 3'h2;
    localparam logic [2:0] CMD_HOLD = 3'h3;
    localparam logic [2:0] CMD_PRESS = 3'h4;
    localparam logic [2:0] CMD_POS = 3'h5;
    localparam int P_ASEL = 0;
    localparam int P_GSEL = 1;
    localparam int P_CLOSE = 2;
    localparam int P_OPEN = 3;
    localparam int P_POSSEL = 4;
    localparam int P_PRESET = 5;
    localparam int P_INIT = 6;
    localparam int NPIN = 7;
    typedef enum logic [1:0] {INIT_SAFE, INIT_RUN, INIT_READY} dvb_init_type;
endpackage : dvb_pkg

// >>> verif/dvb_plant.sv
// Valve plant model: turns the drive outputs into a position word.
// Assumes the block's drive outputs change on the same clock.
module dvb_plant (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic drv_open,
    input wire logic drv_close,
    output logic [15:0] pos
);
    timeunit 1ns;
    timeprecision 1ps;
    // Large steps keep a full stroke near twenty cycles; no drive holds position.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 16'h1388;
        end else if (drv_close && !drv_open) begin
            pos <= (pos > 16'h01F4) ? pos - 16'h01F4 : 16'h0000;
        end else if (drv_open && !drv_close) begin
            pos <= (pos < 16'h251C) ? pos + 16'h01F4 : 16'h2710;
        end
    end
endmodule : dvb_plant

// >>> verif/dvb_valve_io_tb.sv
// Self-checking bench: AXI4-Lite tasks, pin stimulus and solenoid timing.
// Assumes MS_TICKS of 10 and the plant model closing the position loop.
module dvb_valve_io_tb
    import dvb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, arst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, fault;
    logic asel_n, gsel_n, close_n, open_n, possel_n, preset_n, init_n;
    logic d_open, d_close, atp_n, vc_n, vo_n;
    logic [1:0] bresp, rresp, sol, es;
    logic [3:0] ws;
    logic [7:0] awa, ara;
    logic [15:0] asp, pp, ps, vpos, rot, sp, err;
    logic [19:0] v;
    logic [31:0] wd, rd;
    int n_mismatch, cmp_count;
    dvb_valve_io #(.MS_TICKS(10)) u_dvb_valve_io (.MCLK(mclk), .ARST_N(arst_n),
        .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arr), .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rr), .ANALOG_SETPOINT_SEL_N(asel_n), .SECOND_GAUGE_SEL_N(gsel_n),
        .CLOSE_CMD_N(close_n), .OPEN_CMD_N(open_n), .POSITION_SEL_N(possel_n),
        .PRESET_POS_N(preset_n), .INIT_EN_N(init_n), .ANALOG_SP(asp), .PRESS_PRIMARY(pp),
        .PRESS_SECONDARY(ps), .VALVE_POS(vpos), .ROTARY_POS(rot), .DRIVE_OPEN(d_open),
        .DRIVE_CLOSE(d_close), .FAULT(fault), .AT_PRESET_N(atp_n), .VALVE_CLOSED_N(vc_n),
        .VALVE_OPEN_N(vo_n), .SOLENOID_ON(sol));
    dvb_plant u_dvb_plant (.clk(mclk), .rst_n(arst_n), .drv_open(d_open),
        .drv_close(d_close), .pos(vpos));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask : tick
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // The small delay lets the released valid land before the loop test.
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge mclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            #1;
        end while (awv || wv);
        do @(posedge mclk); while (bv !== 1'b1);
        br <= 1'b0;
        chk("bresp", 32'h0, 32'(bresp));
        tick(1);
    endtask : axw
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge mclk);
            if (arr) arv <= 1'b0;
            #1;
        end while (arv);
        do @(posedge mclk); while (rv !== 1'b1);
        rr <= 1'b0;
        chk(nm, e, rd);
        chk("rresp", (a == 8'hF0) ? 32'h2 : 32'h0, 32'(rresp));
        tick(1);
    endtask : rchk
    function automatic logic [1:0] exp_sol(input logic [15:0] e);
        return {e > 16'h01F4, e > 16'h05DC};
    endfunction : exp_sol
    initial begin
        tick(20000);
        n_mismatch++;
        print_verdict();
    end
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {awv, wv, br, arv, rr, arst_n} = 6'h00;
        {awa, ara, wd, ws} = {48'h0, 4'hF};
        {asel_n, gsel_n, close_n, open_n, possel_n, preset_n, init_n} = 7'h7F;
        {asp, pp, ps, rot} = 64'h0;
        n_mismatch = 0;
        cmp_count = 0;
        void'($urandom(63405));
        tick(4);
        arst_n <= 1'b1;
        tick(1);
        rchk("range1 rst", ADDR_RANGE1, {4'h1, 8'h00, RANGE1_RST});
        rchk("time0 rst", ADDR_TIME0, {17'h0, TIME_RST});
        rchk("unmapped", 8'hF0, 32'h0);
        axw(ADDR_TIME1, 32'h00009C40);
        rchk("time clamp", ADDR_TIME1, 32'h00007530);
        for (int i = 0; i < 4; i++) begin
            v = 20'($urandom_range(1, 32'hFFFFF));
            asel_n <= 1'($urandom);
            axw(ADDR_RANGE1, {12'h0, v});
            rchk("range1", ADDR_RANGE1, {4'h1, 8'h00, v});
        end
        axw(ADDR_RANGE2, {12'h0, v});
        rchk("range2", ADDR_RANGE2, {4'h2, 8'h00, v});
        tick(30);
        chk("fault eq", 32'h1, 32'(fault));
        axw(ADDR_RANGE1, 32'h000186A0);
        axw(ADDR_RANGE2, 32'h00000032);
        tick(30);
        rchk("ratio", ADDR_RATIO, 32'h000003E8);
        chk("fault ratio", 32'h1, 32'(fault));
        axw(ADDR_RANGE2, 32'h0);
        axw(ADDR_RANGE1, 32'h000003E8);
        tick(30);
        chk("fault clear", 32'h0, 32'(fault));
        asel_n <= 1'b1;
        init_n <= 1'b0;
        tick(40);
        chk("init closed", 32'h0, 32'(vc_n));
        open_n <= 1'b0;
        tick(6);
        chk("drive open", 32'h1, 32'(d_open));
        tick(2);
        chk("not closed", 32'h1, 32'(vc_n));
        open_n <= 1'b1;
        tick(6);
        chk("stop", 32'h0, 32'(d_open));
        chk("not open", 32'h1, 32'(vo_n));
        close_n <= 1'b0;
        tick(6);
        chk("drive close", 32'h1, 32'(d_close));
        tick(40);
        chk("closed", 32'h0, 32'(vc_n));
        close_n <= 1'b1;
        open_n <= 1'b0;
        tick(40);
        chk("opened", 32'h0, 32'(vo_n));
        open_n <= 1'b1;
        rot <= 16'(10000 - $urandom_range(0, 50));
        tick(3);
        chk("at preset", 32'h0, 32'(atp_n));
        rot <= 16'h0FA0;
        preset_n <= 1'b0;
        tick(6);
        chk("off preset", 32'h1, 32'(atp_n));
        chk("preset drive", 32'h1, 32'(d_close));
        preset_n <= 1'b1;
        ws <= 4'h1;
        axw(ADDR_DELTA0, 32'hFFFF_FF11);
        ws <= 4'hF;
        rchk("strobe", ADDR_DELTA0, 32'h0000_0311);
        axw(ADDR_BURP_EN, 32'h3);
        axw(ADDR_DELTA0, 32'h05DC);
        axw(ADDR_DELTA1, 32'h01F4);
        axw(ADDR_TIME0, 32'h8);
        axw(ADDR_TIME1, 32'h3);
        // The unused gauge reads the set point, so picking it would fire nothing.
        for (int k = 0; k < 2; k++) begin
            sp = 16'($urandom_range(4000, 6000));
            err = 16'(k ? $urandom_range(501, 1499) : $urandom_range(1501, 3000));
            es = exp_sol(err);
            gsel_n <= (k == 0);
            pp <= k ? sp : sp - err;
            ps <= k ? sp - err : sp;
            axw(ADDR_SETPT, {16'h0, sp});
            axw(ADDR_CMD, {29'h0, CMD_PRESS});
            tick(6);
            chk("burp start", 32'(es), 32'(sol));
            tick(44);
            chk("burp one", 32'(es & 2'h1), 32'(sol));
            tick(60);
            chk("burp off", 32'h0, 32'(sol));
            axw(ADDR_CMD, {29'h0, CMD_HOLD});
        end
        asp <= 16'h0000;
        possel_n <= 1'b0;
        asel_n <= 1'b0;
        tick(8);
        chk("serial kept", 32'h0, 32'(d_close));
        asel_n <= 1'b1;
        tick(2010);
        asel_n <= 1'b0;
        tick(10);
        chk("analog pos", 32'h1, 32'(d_close));
        print_verdict();
    end
endmodule : dvb_valve_io_tb
